//--- src/vtps_top.sv
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module vtps_top
	import vtps_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          reset_n,
	input  wire vtps_apb_req_t apb_req,
	output vtps_apb_rsp_t      apb_rsp,
	input  wire vtps_video_t   video_in,
	output vtps_video_t        video_out
);

	// register state
	logic [7:0]             pattern_generator_control;
	logic [7:0]             custom_red_level;
	logic [7:0]             custom_green_level;
	logic [7:0]             custom_blue_level;
	logic [1:0]             mode;
	logic [VTPS_SPAN_W-1:0] hspan;
	logic [VTPS_SPAN_W-1:0] vspan;
	logic [7:0]             next_control;
	logic [7:0]             next_red;
	logic [7:0]             next_green;
	logic [7:0]             next_blue;
	logic [1:0]             next_mode;
	logic [VTPS_SPAN_W-1:0] next_hspan;
	logic [VTPS_SPAN_W-1:0] next_vspan;
	vtps_apb_rsp_t          next_apb_rsp;

	// generator state
	logic                   de_d;
	logic                   vs_d;
	logic [VTPS_SPAN_W-1:0] line_count;
	logic [3:0]             auto_code;
	logic [7:0]             auto_frames;
	vtps_video_t            next_video_out;
	logic                   next_de_d;
	logic                   next_vs_d;
	logic [VTPS_SPAN_W-1:0] next_line_count;
	logic [3:0]             next_auto_code;
	logic [7:0]             next_auto_frames;

	logic                   generator_on;
	logic                   colour_bars_on;
	logic                   compliance_pattern_on;
	logic [3:0]             fixed_pattern_select;
	logic                   invert_on;
	logic                   auto_scroll_on;
	logic [3:0]             active_code;
	logic [7:0]             hlevel;
	logic [7:0]             vlevel;
	logic                   frame_start;
	logic                   line_end;
	logic                   access;
	logic [31:0]            rdata;
	logic                   hit;

	assign generator_on          = pattern_generator_control[VTPS_CTRL_EN_BIT];
	assign colour_bars_on        = pattern_generator_control[VTPS_CTRL_BARS_BIT];
	assign compliance_pattern_on = pattern_generator_control[VTPS_CTRL_COMP_BIT];
	assign fixed_pattern_select  = pattern_generator_control[VTPS_CTRL_SEL_LSB +: 4];
	assign invert_on             = mode[VTPS_MODE_INV_BIT];
	assign auto_scroll_on        = mode[VTPS_MODE_AUTO_BIT];
	assign frame_start           = video_in.vs && !vs_d;
	assign line_end              = vs_d == video_in.vs && de_d && !video_in.de;

	// auto-scroll walks the codes, so the select field plays no part then
	assign active_code = auto_scroll_on ? auto_code : fixed_pattern_select;

	// colour of a channel mask at a given level
	function automatic logic [23:0] tint(input logic [2:0] rgb_mask, input logic [7:0] lvl);
		tint = {rgb_mask[2] ? lvl : 8'h00, rgb_mask[1] ? lvl : 8'h00, rgb_mask[0] ? lvl : 8'h00};
	endfunction : tint

	// which channels a code lights: ramps use white, red, green, blue in order
	function automatic logic [2:0] channels(input logic [3:0] code);
		logic [1:0] pos;
		pos = 2'b00;
		if (code >= VTPS_CODE_VR_FIRST)
			pos = 2'(code - VTPS_CODE_VR_FIRST);
		else if (code >= VTPS_CODE_HR_FIRST)
			pos = 2'(code - VTPS_CODE_HR_FIRST);
		unique case (pos)
			2'h0:    channels = 3'b111;
			2'h1:    channels = 3'b100;
			2'h2:    channels = 3'b010;
			default: channels = 3'b001;
		endcase
	endfunction : channels

	vtps_ramp u_hramp (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clear   (!video_in.de),
		.step    (video_in.de),
		.span    (hspan),
		.level   (hlevel)
	);

	vtps_ramp u_vramp (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.clear   (frame_start),
		.step    (line_end),
		.span    (vspan),
		.level   (vlevel)
	);

	// register file: one wait state on every access
	always_comb begin
		access       = apb_req.psel && apb_req.penable && !apb_rsp.pready;
		next_control = pattern_generator_control;
		next_red     = custom_red_level;
		next_green   = custom_green_level;
		next_blue    = custom_blue_level;
		next_mode    = mode;
		next_hspan   = hspan;
		next_vspan   = vspan;
		hit          = 1'b1;
		rdata        = 32'h0000_0000;
		unique case (apb_req.paddr)
			VTPS_ADDR_CTRL:   rdata = {24'h00_0000, pattern_generator_control};
			VTPS_ADDR_RED:    rdata = {24'h00_0000, custom_red_level};
			VTPS_ADDR_GREEN:  rdata = {24'h00_0000, custom_green_level};
			VTPS_ADDR_BLUE:   rdata = {24'h00_0000, custom_blue_level};
			VTPS_ADDR_MODE:   rdata = {30'h0000_0000, mode};
			VTPS_ADDR_HSPAN:  rdata = {20'h0_0000, hspan};
			VTPS_ADDR_VSPAN:  rdata = {20'h0_0000, vspan};
			VTPS_ADDR_STATUS: rdata = {4'h0, line_count, 11'h000, generator_on, active_code};
			default:          hit   = 1'b0;
		endcase
		if (access && apb_req.pwrite) begin
			unique case (apb_req.paddr)
				VTPS_ADDR_CTRL:  next_control = apb_req.pwdata[7:0];
				VTPS_ADDR_RED:   next_red     = apb_req.pwdata[7:0];
				VTPS_ADDR_GREEN: next_green   = apb_req.pwdata[7:0];
				VTPS_ADDR_BLUE:  next_blue    = apb_req.pwdata[7:0];
				VTPS_ADDR_MODE:  next_mode    = apb_req.pwdata[1:0];
				VTPS_ADDR_HSPAN: next_hspan   = apb_req.pwdata[VTPS_SPAN_W-1:0];
				VTPS_ADDR_VSPAN: next_vspan   = apb_req.pwdata[VTPS_SPAN_W-1:0];
				default:         ;
			endcase
		end
		next_apb_rsp.pready  = access;
		next_apb_rsp.pslverr = access && (!hit || (apb_req.pwrite && apb_req.paddr == VTPS_ADDR_STATUS));
		next_apb_rsp.prdata  = (access && !apb_req.pwrite && hit) ? rdata : 32'h0000_0000;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pattern_generator_control <= VTPS_CTRL_RESET;
			custom_red_level          <= 8'h00;
			custom_green_level        <= 8'h00;
			custom_blue_level         <= 8'h00;
			mode                      <= 2'h0;
			hspan                     <= VTPS_HSPAN_RESET;
			vspan                     <= VTPS_VSPAN_RESET;
			apb_rsp                   <= '0;
		end else begin
			pattern_generator_control <= next_control;
			custom_red_level          <= next_red;
			custom_green_level        <= next_green;
			custom_blue_level         <= next_blue;
			mode                      <= next_mode;
			hspan                     <= next_hspan;
			vspan                     <= next_vspan;
			apb_rsp                   <= next_apb_rsp;
		end
	end

	// pixel generation
	always_comb begin
		logic [23:0] px;
		logic [2:0]  bar;
		px               = 24'h00_0000;
		bar              = ~hlevel[7:5];
		next_de_d        = video_in.de;
		next_vs_d        = video_in.vs;
		next_line_count  = line_count;
		next_auto_code   = auto_code;
		next_auto_frames = auto_frames;
		if (frame_start)
			next_line_count = '0;
		else if (line_end)
			next_line_count = line_count + 12'h001;
		if (!auto_scroll_on) begin
			next_auto_code   = VTPS_CODE_WHITE;
			next_auto_frames = 8'h00;
		end else if (frame_start) begin
			if (auto_frames == VTPS_AUTO_FRAMES - 8'h01) begin
				next_auto_frames = 8'h00;
				next_auto_code   = (auto_code == VTPS_CODE_LAST) ? VTPS_CODE_WHITE
				                                                 : auto_code + 4'h1;
			end else begin
				next_auto_frames = auto_frames + 8'h01;
			end
		end
		if (compliance_pattern_on) begin
			px = (hlevel[0] ^ line_count[0]) ? 24'hFF_FFFF : 24'h00_0000;
		end else if (colour_bars_on) begin
			px = tint({bar[1], bar[2], bar[0]}, 8'hFF);
		end else begin
			unique case (active_code)
				VTPS_CODE_WHITE: px = 24'hFF_FFFF;
				VTPS_CODE_BLACK: px = 24'h00_0000;
				VTPS_CODE_RED:   px = 24'hFF_0000;
				VTPS_CODE_GREEN: px = 24'h00_FF00;
				VTPS_CODE_BLUE:  px = 24'h00_00FF;
				4'h6, 4'h7, 4'h8, 4'h9:
					px = tint(channels(active_code), hlevel);
				4'hA, 4'hB, 4'hC, 4'hD:
					px = tint(channels(active_code), vlevel);
				VTPS_CODE_CUSTOM:
					px = {custom_red_level, custom_green_level, custom_blue_level};
				// reserved codes 0 and 15 fall back to black
				default: px = 24'h00_0000;
			endcase
			// complement gives the second colour, and white-to-complement ramps
			if (invert_on)
				px = ~px;
		end
		next_video_out = video_in;
		if (generator_on && video_in.de)
			{next_video_out.r, next_video_out.g, next_video_out.b} = px;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			de_d        <= 1'b0;
			vs_d        <= 1'b0;
			line_count  <= '0;
			auto_code   <= VTPS_CODE_WHITE;
			auto_frames <= 8'h00;
			video_out   <= '0;
		end else begin
			de_d        <= next_de_d;
			vs_d        <= next_vs_d;
			line_count  <= next_line_count;
			auto_code   <= next_auto_code;
			auto_frames <= next_auto_frames;
			video_out   <= next_video_out;
		end
	end

endmodule : vtps_top
`default_nettype wire

//--- src/vtps_pkg.sv
package vtps_pkg;

	localparam int          VTPS_AW            = 8;
	localparam int          VTPS_SPAN_W        = 12;

	// byte addresses of the register map
	localparam logic [7:0]  VTPS_ADDR_CTRL     = 8'h64;
	localparam logic [7:0]  VTPS_ADDR_RED      = 8'h80;
	localparam logic [7:0]  VTPS_ADDR_GREEN    = 8'h84;
	localparam logic [7:0]  VTPS_ADDR_BLUE     = 8'h88;
	localparam logic [7:0]  VTPS_ADDR_MODE     = 8'h8C;
	localparam logic [7:0]  VTPS_ADDR_HSPAN    = 8'h90;
	localparam logic [7:0]  VTPS_ADDR_VSPAN    = 8'h94;
	localparam logic [7:0]  VTPS_ADDR_STATUS   = 8'h98;

	// control register fields
	localparam int          VTPS_CTRL_EN_BIT   = 0;
	localparam int          VTPS_CTRL_REV_BIT  = 1;
	localparam int          VTPS_CTRL_BARS_BIT = 2;
	localparam int          VTPS_CTRL_COMP_BIT = 3;
	localparam int          VTPS_CTRL_SEL_LSB  = 4;
	localparam logic [7:0]  VTPS_CTRL_RESET    = 8'h10;

	// mode register fields
	localparam int          VTPS_MODE_INV_BIT  = 0;
	localparam int          VTPS_MODE_AUTO_BIT = 1;

	localparam logic [11:0] VTPS_HSPAN_RESET   = 12'h780;
	localparam logic [11:0] VTPS_VSPAN_RESET   = 12'h438;
	localparam logic [7:0]  VTPS_AUTO_FRAMES   = 8'h3C;
	localparam logic [7:0]  VTPS_RAMP_STEP     = 8'hFF;

	localparam logic [3:0]  VTPS_CODE_WHITE    = 4'h1;
	localparam logic [3:0]  VTPS_CODE_BLACK    = 4'h2;
	localparam logic [3:0]  VTPS_CODE_RED      = 4'h3;
	localparam logic [3:0]  VTPS_CODE_GREEN    = 4'h4;
	localparam logic [3:0]  VTPS_CODE_BLUE     = 4'h5;
	localparam logic [3:0]  VTPS_CODE_HR_FIRST = 4'h6;
	localparam logic [3:0]  VTPS_CODE_HR_LAST  = 4'h9;
	localparam logic [3:0]  VTPS_CODE_VR_FIRST = 4'hA;
	localparam logic [3:0]  VTPS_CODE_VR_LAST  = 4'hD;
	localparam logic [3:0]  VTPS_CODE_CUSTOM   = 4'hE;
	localparam logic [3:0]  VTPS_CODE_LAST     = 4'hE;

	typedef struct packed {
		logic        vs;
		logic        hs;
		logic        de;
		logic [7:0]  r;
		logic [7:0]  g;
		logic [7:0]  b;
	} vtps_video_t;

	typedef struct packed {
		logic               psel;
		logic               penable;
		logic               pwrite;
		logic [VTPS_AW-1:0] paddr;
		logic [31:0]        pwdata;
	} vtps_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} vtps_apb_rsp_t;

endpackage : vtps_pkg

//--- src/vtps_ramp.sv
`timescale 1ns/100ps
`default_nettype none
// even spread of 0..255 over span steps when span is 255 or more, integer stepping with no divider
module vtps_ramp
	import vtps_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   clear,
	input  wire logic                   step,
	input  wire logic [VTPS_SPAN_W-1:0] span,
	output logic      [7:0]             level
);

	logic [VTPS_SPAN_W-1:0] acc;
	logic [VTPS_SPAN_W-1:0] next_acc;
	logic [7:0]             next_level;
	logic [VTPS_SPAN_W:0]   sum;

	always_comb begin
		sum        = {1'b0, acc} + {{(VTPS_SPAN_W - 7){1'b0}}, VTPS_RAMP_STEP};
		next_acc   = acc;
		next_level = level;
		if (clear) begin
			next_acc   = '0;
			next_level = '0;
		end else if (step) begin
			// spans below 255 climb one level per step and hold at full scale
			if (sum >= {1'b0, span} && level != 8'hFF) begin
				next_acc   = VTPS_SPAN_W'(sum - {1'b0, span});
				next_level = level + 8'h01;
			end else begin
				next_acc   = sum[VTPS_SPAN_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc   <= '0;
			level <= '0;
		end else begin
			acc   <= next_acc;
			level <= next_level;
		end
	end

endmodule : vtps_ramp
`default_nettype wire

//--- test/vtps_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module vtps_top_asserts
	import vtps_pkg::*;
(
	input wire logic          ref_clk,
	input wire logic          reset_n,
	input wire vtps_apb_req_t apb_req,
	input wire vtps_apb_rsp_t apb_rsp,
	input wire vtps_video_t   video_in,
	input wire vtps_video_t   video_out
);
	logic gen_on;
	logic next_gen_on;
	logic mapped;
	// shadow of the enable bit; it lags the real bit by one edge, matching the pixel pipe
	always_comb begin
		next_gen_on = gen_on;
		if (apb_rsp.pready && apb_req.pwrite && apb_req.paddr == VTPS_ADDR_CTRL) begin
			next_gen_on = apb_req.pwdata[VTPS_CTRL_EN_BIT];
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gen_on <= 1'b0;
		end else begin
			gen_on <= next_gen_on;
		end
	end
	assign mapped = apb_req.paddr inside {VTPS_ADDR_CTRL, VTPS_ADDR_RED, VTPS_ADDR_GREEN,
		VTPS_ADDR_BLUE, VTPS_ADDR_MODE, VTPS_ADDR_HSPAN, VTPS_ADDR_VSPAN, VTPS_ADDR_STATUS};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_wait;
		apb_req.penable && !apb_rsp.pready;
	endsequence
	a_one_wait: assert property (s_setup |=> s_wait ##1 apb_rsp.pready)
		else $error("pready not after exactly one wait state");
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held longer than one cycle");
	a_rdata_idle: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
		else $error("read data not zero outside completion");
	a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
		else $error("pready outside an access phase");
	a_unmapped_err: assert property (apb_rsp.pready && !mapped |-> apb_rsp.pslverr)
		else $error("no error for unmapped address");
	a_mapped_ok: assert property (apb_rsp.pready && mapped
		&& !(apb_req.pwrite && apb_req.paddr == VTPS_ADDR_STATUS) |-> !apb_rsp.pslverr)
		else $error("error on a legal access");
	a_sync_delay: assert property ($past(reset_n) |-> {video_out.vs, video_out.hs, video_out.de}
		== $past({video_in.vs, video_in.hs, video_in.de}))
		else $error("sync and enable not delayed by one clock");
	a_blank_pass: assert property ($past(reset_n) && !$past(video_in.de) |->
		{video_out.r, video_out.g, video_out.b} == $past({video_in.r, video_in.g, video_in.b}))
		else $error("blanking pixel altered");
	a_off_pass: assert property ($past(reset_n) && !gen_on |-> video_out == $past(video_in))
		else $error("video altered while generator off");
endmodule : vtps_top_asserts
`default_nettype wire

//--- test/vtps_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module vtps_top_tb_top
	import vtps_pkg::*;
;
	logic          ref_clk;
	logic          reset_n;
	vtps_apb_req_t apb_req;
	vtps_apb_rsp_t apb_rsp;
	vtps_video_t   video_in;
	vtps_video_t   video_out;
	int            mismatches = 0;
	int            samples_checked = 0;
	int            cycles = 0;
	int            col = 0;
	logic [23:0]   px [0:255];
	logic [23:0]   keep [0:7];
	logic [31:0]   rd;
	logic          err;
	vtps_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.video_in(video_in), .video_out(video_out));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// one captured entry per output pixel of the current active run
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		col <= (video_out.de === 1'b1) ? col + 1 : 0;
		if (video_out.de === 1'b1) begin
			px[col[7:0]] <= {video_out.r, video_out.g, video_out.b};
		end
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic summarize();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int n;
		n = 0;
		@(posedge ref_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			mismatches++;
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb
	task automatic line(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			video_in <= '{vs: 1'b0, hs: 1'b0, de: 1'b1, r: 8'h12, g: 8'h34, b: 8'h56};
		end
		@(posedge ref_clk);
		video_in.de <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : line
	task automatic vsync();
		@(posedge ref_clk);
		video_in.vs <= 1'b1;
		@(posedge ref_clk);
		video_in.vs <= 1'b0;
	endtask : vsync
	task automatic run(input logic [31:0] mode, input logic [31:0] ctrl, input int n);
		apb(1'b1, VTPS_ADDR_MODE, mode);
		apb(1'b1, VTPS_ADDR_CTRL, ctrl); // callers never pass select codes 0 or 15
		vsync();
		line(n);
	endtask : run
	task automatic t_regs();
		apb(1'b0, VTPS_ADDR_CTRL, 32'h0);
		check(rd, 32'h0000_0010);
		apb(1'b0, 8'h00, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, VTPS_ADDR_STATUS, 32'hFF);
		check({31'h0, err}, 32'h1);
		line(4);
		check({8'h0, px[0]}, 32'h0012_3456);
		// one line since reset, generator off, select still at its reset code
		apb(1'b0, VTPS_ADDR_STATUS, 32'h0);
		check(rd, 32'h0001_0001);
		apb(1'b1, VTPS_ADDR_CTRL, 32'hFFFF_FFFF);
		apb(1'b0, VTPS_ADDR_CTRL, 32'h0);
		check(rd, 32'h0000_00FF);
	endtask : t_regs
	task automatic t_solid();
		logic [23:0] plain [5] = '{24'hFFFFFF, 24'h000000, 24'hFF0000, 24'h00FF00, 24'h0000FF};
		for (int c = 1; c <= 5; c++) begin
			for (int v = 0; v < 2; v++) begin
				run(32'(v), {4'(c), 4'h1}, 2);
				check({8'h0, px[0]}, {8'h0, (v ? ~plain[c-1] : plain[c-1])});
			end
		end
	endtask : t_solid
	task automatic t_hramp();
		logic [23:0] mask [4] = '{24'hFFFFFF, 24'hFF0000, 24'h00FF00, 24'h0000FF};
		int bad;
		bad = 0;
		apb(1'b1, VTPS_ADDR_HSPAN, 32'd256);
		for (int c = 6; c <= 9; c++) begin
			run(32'h0, {4'(c), 4'h1}, 256);
			check({8'h0, px[0]}, 32'h0);
			check({8'h0, px[255] & ~mask[c-6]}, 32'h0);
			check({31'h0, ((px[255] | ~mask[c-6]) & 24'hF8F8F8) == 24'hF8F8F8}, 32'h1);
		end
		for (int i = 1; i < 256; i++) begin
			bad += (px[i][7:0] < px[i-1][7:0]) ? 1 : 0;
		end
		check(32'(bad), 32'h0);
		check({31'h0, px[128][7:0] inside {[8'h7E:8'h82]}}, 32'h1);
		run(32'h1, 32'h61, 256);
		check({8'h0, px[0]}, 32'h00FF_FFFF);
		check({31'h0, px[255] < 24'h080808}, 32'h1);
	endtask : t_hramp
	task automatic t_vramp();
		apb(1'b1, VTPS_ADDR_HSPAN, 32'd8);
		apb(1'b1, VTPS_ADDR_VSPAN, 32'd4);
		run(32'h0, 32'hA1, 8);
		check({8'h0, px[0] | px[7]}, 32'h0);
		line(8);
		line(8);
		check({31'h0, px[0] != 24'h0}, 32'h1);
		check({8'h0, px[7]}, {8'h0, px[0]});
		run(32'h1, 32'hA1, 8);
		check({8'h0, px[0]}, 32'h00FF_FFFF);
	endtask : t_vramp
	task automatic t_custom();
		apb(1'b1, VTPS_ADDR_RED, 32'h11);
		apb(1'b1, VTPS_ADDR_GREEN, 32'h22);
		apb(1'b1, VTPS_ADDR_BLUE, 32'h33);
		run(32'h0, 32'hE1, 2);
		check({8'h0, px[0]}, 32'h0011_2233);
		run(32'h1, 32'hE1, 2);
		check({8'h0, px[0]}, 32'h00EE_DDCC);
	endtask : t_custom
	task automatic t_override();
		run(32'h0, 32'h25, 2);
		check({8'h0, px[0]}, 32'h00FF_FFFF);
		run(32'h0, 32'h19, 8);
		for (int i = 0; i < 8; i++) begin
			keep[i] = px[i];
		end
		run(32'h0, 32'h39, 8);
		for (int i = 0; i < 8; i++) begin
			check({8'h0, px[i]}, {8'h0, keep[i]});
		end
		// span 8 puts level 1 on pixel 1 of line 0, a white square of the checkerboard
		check({8'h0, keep[1]}, 32'h00FF_FFFF);
		// auto-scroll starts from code 1 whatever the select field holds
		apb(1'b1, VTPS_ADDR_MODE, 32'h2);
		apb(1'b1, VTPS_ADDR_CTRL, 32'h21);
		line(2);
		check({8'h0, px[0]}, 32'h00FF_FFFF);
		apb(1'b1, VTPS_ADDR_MODE, 32'h0);
		apb(1'b1, VTPS_ADDR_CTRL, 32'h20);
		line(2);
		check({8'h0, px[0]}, 32'h0012_3456);
	endtask : t_override
	initial begin
		reset_n = 1'b0;
		apb_req = '0;
		video_in = '0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_regs();
		t_solid();
		t_hramp();
		t_vramp();
		t_custom();
		t_override();
		summarize();
	end
endmodule : vtps_top_tb_top
bind vtps_top vtps_top_asserts u_asserts (.ref_clk(ref_clk), .reset_n(reset_n),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .video_in(video_in), .video_out(video_out));
`default_nettype wire
